// File: verilog/bus_pin_logic.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RULE1] Mux select low for row, high column
// [RULE2] Boot pin sampled in and after reset
// [RULE3] Boot: 0=8bit, 1=32bit, follows reset=16bit
// [RULE4] Low fault input flags transfer error
// [RULE5] Fault sampled only in data/last wait
// [RULE6] Under hold grant, request when op pending
// [RULE7] Without grant, pin is fly-by strobe
// [RULE8] Slow transfers: one-cycle strobe pulse
// [RULE9] Full-rate burst: strobe held throughout
// [RULE10] Four column strobes, one per lane
// [RULE11] Critical irq: low cycle then high cycle
// [RULE12] Selects 0 and 1 serve SRAM banks
// [RULE13] Address bit 29 output only when owner
// [RULE14] Selects, irq, DMA lines active low
// [RULE15] Synchronise irq and fault inputs
module bus_pin_logic
  import pin_logic_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              RSTN,
  input  wire logic              DRAM_COL_PHASE,
  input  wire logic [LANES-1:0]  DRAM_LANE_EN,
  input  wire logic [1:0]        BANK_IS_SRAM,
  input  wire logic              SRAM_ACCESS,
  input  wire logic              SRAM_BANK,
  input  wire logic              XFER_DATA_CYCLE,
  input  wire logic              XFER_LAST_WAIT,
  input  wire logic              HOLD_GRANT,
  input  wire logic              OP_PENDING,
  input  wire logic [GRANTS-1:0] DMA_GRANT_LINES_N,
  input  wire logic              DMA_XFER_DONE,
  input  wire logic              DMA_BURST_ACTIVE,
  input  wire logic              CORE_ADDR_29,
  input  wire logic              BOOT_WIDTH_SELECT,
  input  wire logic              TRANSACTION_FAULT_IN_N,
  input  wire logic              CRITICAL_IRQ_IN_N,
  input  wire logic              ADDR_BIT_29_I,
  output logic                   ADDR_BIT_29_O,
  output logic                   ADDR_BIT_29_OE,
  output logic                   PAGE_ADDR_29,
  output logic                   DRAM_ADDR_MUX_SELECT,
  output logic [LANES-1:0]       COLUMN_STROBE_N,
  output logic                   SRAM_SELECT_BANK0_N,
  output logic                   SRAM_SELECT_BANK1_N,
  output logic                   SHARED_REQ_STROBE_N,
  output logic [1:0]             BOOT_WIDTH,
  output logic                   BOOT_WIDTH_VALID,
  output logic                   FAULT_DETECTED,
  output logic                   CRITICAL_IRQ
);

  typedef struct packed {
    logic            mux_sel;
    logic [3:0]      cas_n;
    logic            cs0_n;
    logic            cs1_n;
    logic            shared_n;
    logic            a29_o;
    logic            a29_oe;
    logic            a29_page;
    logic            boot_in_rst;
    logic            boot_valid;
    boot_width_t     boot_w;
    logic            fault;
    ci_state_t       ci;
    logic            irq;
  } pin_state_t;

  pin_state_t s_q;
  pin_state_t s_d;
  logic       boot_pin_q;
  logic       any_grant;
  pin_sync_if sif ();

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  pin_input_sync u_sync (
    .clk         (CORE_CLK),
    .rst_n       (RSTN),
    .crit_n_pin  (CRITICAL_IRQ_IN_N),
    .fault_n_pin (TRANSACTION_FAULT_IN_N),
    .sif         (sif)
  );

  // Free-running sampler, no reset, so it keeps tracking the pin during reset
  always_ff @(posedge CORE_CLK) begin
    boot_pin_q <= BOOT_WIDTH_SELECT; // RULE2
  end

  assign any_grant = DMA_GRANT_LINES_N != GRANTS_IDLE; // RULE14

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.mux_sel  = DRAM_COL_PHASE ? SEL_COL : SEL_ROW; // RULE1
    s_d.cas_n    = DRAM_COL_PHASE ? ~DRAM_LANE_EN : STROBES_IDLE; // RULE10
    s_d.cs0_n    = !(SRAM_ACCESS && SRAM_BANK == BANK0 && BANK_IS_SRAM[0]); // RULE12
    s_d.cs1_n    = !(SRAM_ACCESS && SRAM_BANK == BANK1 && BANK_IS_SRAM[1]); // RULE12
    if (HOLD_GRANT) begin
      s_d.shared_n = !OP_PENDING; // RULE6
    end else begin
      // Burst keeps the strobe low; slower rates give one pulse per handover
      s_d.shared_n = !(any_grant && (DMA_BURST_ACTIVE || DMA_XFER_DONE)); // RULE7 RULE8 RULE9
    end
    s_d.a29_oe   = !HOLD_GRANT; // RULE13
    s_d.a29_o    = CORE_ADDR_29;
    if (HOLD_GRANT) begin
      s_d.a29_page = ADDR_BIT_29_I; // RULE13
    end
    if (!s_q.boot_valid) begin
      // Old sample is the last one taken with reset still low
      s_d.boot_in_rst = boot_pin_q; // RULE2
      s_d.boot_valid  = 1'b1;
      s_d.boot_w      = boot_decode(boot_pin_q, BOOT_WIDTH_SELECT); // RULE3
    end
    s_d.fault    = !sif.fault_n_s && (XFER_DATA_CYCLE || XFER_LAST_WAIT); // RULE4 RULE5
    s_d.irq      = 1'b0;
    unique case (s_q.ci)
      CI_IDLE: begin
        if (!sif.crit_n_s) begin
          s_d.ci = CI_LOW; // RULE11
        end
      end
      CI_LOW: begin
        if (sif.crit_n_s) begin
          s_d.ci  = CI_IDLE;
          s_d.irq = 1'b1; // RULE11
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '{SEL_ROW, STROBES_IDLE, PIN_IDLE_N, PIN_IDLE_N, PIN_IDLE_N,
               1'b0, 1'b0, 1'b0, 1'b0, 1'b0, BOOT_W8, 1'b0, CI_IDLE, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign DRAM_ADDR_MUX_SELECT = s_q.mux_sel;
  assign COLUMN_STROBE_N      = s_q.cas_n;
  assign SRAM_SELECT_BANK0_N  = s_q.cs0_n;
  assign SRAM_SELECT_BANK1_N  = s_q.cs1_n;
  assign SHARED_REQ_STROBE_N  = s_q.shared_n;
  assign ADDR_BIT_29_O        = s_q.a29_o;
  assign ADDR_BIT_29_OE       = s_q.a29_oe;
  assign PAGE_ADDR_29         = s_q.a29_page;
  assign BOOT_WIDTH           = s_q.boot_w;
  assign BOOT_WIDTH_VALID     = s_q.boot_valid;
  assign FAULT_DETECTED       = s_q.fault;
  assign CRITICAL_IRQ         = s_q.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  property p_mux_sel;
    1'b1 |=> DRAM_ADDR_MUX_SELECT == $past(DRAM_COL_PHASE);
  endproperty
  a_mux_sel: assert property (p_mux_sel) // RULE1
    else $error("Mux select does not follow the column phase");

  property p_boot_hold;
    BOOT_WIDTH_VALID |=> BOOT_WIDTH_VALID && $stable(BOOT_WIDTH);
  endproperty
  a_boot_hold: assert property (p_boot_hold) // RULE2
    else $error("Boot width changed after capture");

  property p_boot_16;
    $rose(BOOT_WIDTH_VALID) && !s_q.boot_in_rst && $past(BOOT_WIDTH_SELECT)
      |-> BOOT_WIDTH == BOOT_W16;
  endproperty
  a_boot_16: assert property (p_boot_16) // RULE3
    else $error("Pin following reset did not give 16-bit boot");

  property p_fault_set;
    !sif.fault_n_s && XFER_DATA_CYCLE |=> FAULT_DETECTED;
  endproperty
  a_fault_set: assert property (p_fault_set) // RULE4
    else $error("Fault in data cycle not reported");

  property p_fault_window;
    !(XFER_DATA_CYCLE || XFER_LAST_WAIT) |=> !FAULT_DETECTED;
  endproperty
  a_fault_window: assert property (p_fault_window) // RULE5
    else $error("Fault reported outside the sampling cycles");

  property p_regain;
    HOLD_GRANT |=> SHARED_REQ_STROBE_N == !$past(OP_PENDING);
  endproperty
  a_regain: assert property (p_regain) // RULE6
    else $error("Regain request does not follow pending operation");

  property p_no_grant;
    !HOLD_GRANT && DMA_GRANT_LINES_N == GRANTS_IDLE |=> SHARED_REQ_STROBE_N;
  endproperty
  a_no_grant: assert property (p_no_grant) // RULE7
    else $error("Strobe active with no DMA grant");

  sequence s_slow_step;
    !HOLD_GRANT && any_grant && DMA_XFER_DONE && !DMA_BURST_ACTIVE
      ##1 !HOLD_GRANT && !DMA_XFER_DONE && !DMA_BURST_ACTIVE;
  endsequence
  property p_slow_pulse;
    s_slow_step |-> !SHARED_REQ_STROBE_N ##1 SHARED_REQ_STROBE_N;
  endproperty
  a_slow_pulse: assert property (p_slow_pulse) // RULE8
    else $error("Slow transfer strobe not a single-cycle pulse");

  sequence s_burst;
    (!HOLD_GRANT && any_grant && DMA_BURST_ACTIVE) [*3];
  endsequence
  property p_burst;
    s_burst |=> !SHARED_REQ_STROBE_N && !$past(SHARED_REQ_STROBE_N);
  endproperty
  a_burst: assert property (p_burst) // RULE9
    else $error("Strobe dropped during full-rate burst");

  property p_cas;
    DRAM_COL_PHASE |=> COLUMN_STROBE_N == ~$past(DRAM_LANE_EN);
  endproperty
  a_cas: assert property (p_cas) // RULE10
    else $error("Column strobes do not match lane enables");

  property p_irq;
    CRITICAL_IRQ |-> $past(s_q.ci) == CI_LOW && $past(sif.crit_n_s) && !$past(CRITICAL_IRQ);
  endproperty
  a_irq: assert property (p_irq) // RULE11
    else $error("Critical irq without low then high input");

  property p_cs0;
    SRAM_ACCESS && SRAM_BANK == BANK0 && BANK_IS_SRAM[0] |=> !SRAM_SELECT_BANK0_N
      && SRAM_SELECT_BANK1_N;
  endproperty
  a_cs0: assert property (p_cs0) // RULE12
    else $error("Bank 0 select wrong");

  property p_a29;
    HOLD_GRANT |=> !ADDR_BIT_29_OE;
  endproperty
  a_a29: assert property (p_a29) // RULE13
    else $error("Address bit 29 driven while external master owns bus");

endmodule : bus_pin_logic
`default_nettype wire

// File: verilog/pin_logic_pkg.sv
`default_nettype none
package pin_logic_pkg;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int          LANES        = 4;
  localparam int          GRANTS       = 4;
  localparam logic        PIN_IDLE_N   = 1'b1;
  localparam logic        SEL_ROW      = 1'b0;
  localparam logic        SEL_COL      = 1'b1;
  localparam logic [3:0]  STROBES_IDLE = 4'hF;
  localparam logic [3:0]  GRANTS_IDLE  = 4'hF;
  localparam logic        BANK0        = 1'b0;
  localparam logic        BANK1        = 1'b1;

  // ----------------------------------------
  // Boot width codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    BOOT_W8  = 2'h0,
    BOOT_W16 = 2'h1,
    BOOT_W32 = 2'h2
  } boot_width_t;

  // ----------------------------------------
  // Critical interrupt handshake states
  // ----------------------------------------
  typedef enum logic {
    CI_IDLE = 1'b0,
    CI_LOW  = 1'b1
  } ci_state_t;

  function automatic boot_width_t boot_decode(input logic in_rst, input logic after_rst);
    boot_width_t w;
    w = BOOT_W8;
    if (in_rst && after_rst) begin
      w = BOOT_W32;
    end else if (!in_rst && after_rst) begin
      w = BOOT_W16;
    end
    return w;
  endfunction : boot_decode

endpackage : pin_logic_pkg
`default_nettype wire

// File: verilog/pin_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic crit_n_s;
  logic fault_n_s;
  modport src (output crit_n_s, output fault_n_s);
  modport dst (input crit_n_s, input fault_n_s);
endinterface : pin_sync_if
`default_nettype wire

// File: verilog/pin_input_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_input_sync
  import pin_logic_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  crit_n_pin,
  input  wire logic  fault_n_pin,
  pin_sync_if.src    sif
);

  typedef struct packed {
    logic crit_1;
    logic crit_2;
    logic fault_1;
    logic fault_2;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // ----------------------------------------
  // Two-stage synchronisers
  // ----------------------------------------
  // Stage one feeds stage two only, so metastability stays contained
  always_comb begin
    s_d         = s_q;
    s_d.crit_1  = crit_n_pin;  // RULE15
    s_d.crit_2  = s_q.crit_1;
    s_d.fault_1 = fault_n_pin; // RULE15
    s_d.fault_2 = s_q.fault_1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{PIN_IDLE_N, PIN_IDLE_N, PIN_IDLE_N, PIN_IDLE_N};
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.crit_n_s  = s_q.crit_2;
  assign sif.fault_n_s = s_q.fault_2;

  property p_sync_delay;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n, 2) |-> (sif.fault_n_s == $past(fault_n_pin, 2))
                       && (sif.crit_n_s == $past(crit_n_pin, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) // RULE15
    else $error("Synchroniser latency is not two cycles");

endmodule : pin_input_sync
`default_nettype wire

// File: tb/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input  wire logic       rstn,
  input  wire logic [1:0] boot_mode,
  input  wire logic       irq_go,
  input  wire logic       fault_on,
  input  wire logic       ext_a29,
  input  wire logic       a29_o,
  input  wire logic       a29_oe,
  output logic            boot_pin,
  output logic            irq_n,
  output logic            fault_n,
  output logic            a29_pin
);
  // ----------------------------------------
  // Strap, fault, irq and shared pin
  // ----------------------------------------
  // Mode 2 ties the strap to reset itself
  assign boot_pin = (boot_mode == 2'h2) ? rstn : boot_mode[0];
  assign fault_n  = ~fault_on;
  // Bench holds irq_go for whole cycles only
  assign irq_n    = ~irq_go;
  // External master drives while device lets go
  assign a29_pin  = a29_oe ? a29_o : ext_a29;
endmodule : board_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pin_logic_pkg::*;
;
  logic       clk, rstn, col, acc, bank, dat, lw, hold, opp, done, burst, ca29, ext;
  logic       irq_go, fault_on, bpin, irq_n, fault_n, a29p, a29o, a29oe, page, mux;
  logic       sel0, sel1, shr, bvalid, fault, irq;
  logic [3:0] lanes, grants, cas;
  logic [1:0] sram, bmode, bw;
  int         n_errors = 0;
  int         num_checks = 0;
  int         nf = 0;
  int         ni = 0;

  bus_pin_logic bus_pin_logic_inst (
    .CORE_CLK(clk), .RSTN(rstn), .DRAM_COL_PHASE(col), .DRAM_LANE_EN(lanes),
    .BANK_IS_SRAM(sram), .SRAM_ACCESS(acc), .SRAM_BANK(bank), .XFER_DATA_CYCLE(dat),
    .XFER_LAST_WAIT(lw), .HOLD_GRANT(hold), .OP_PENDING(opp), .DMA_GRANT_LINES_N(grants),
    .DMA_XFER_DONE(done), .DMA_BURST_ACTIVE(burst), .CORE_ADDR_29(ca29),
    .BOOT_WIDTH_SELECT(bpin), .TRANSACTION_FAULT_IN_N(fault_n), .CRITICAL_IRQ_IN_N(irq_n),
    .ADDR_BIT_29_I(a29p), .ADDR_BIT_29_O(a29o), .ADDR_BIT_29_OE(a29oe), .PAGE_ADDR_29(page),
    .DRAM_ADDR_MUX_SELECT(mux), .COLUMN_STROBE_N(cas), .SRAM_SELECT_BANK0_N(sel0),
    .SRAM_SELECT_BANK1_N(sel1), .SHARED_REQ_STROBE_N(shr), .BOOT_WIDTH(bw),
    .BOOT_WIDTH_VALID(bvalid), .FAULT_DETECTED(fault), .CRITICAL_IRQ(irq));

  board_model board_model_inst (
    .rstn(rstn), .boot_mode(bmode), .irq_go(irq_go), .fault_on(fault_on),
    .ext_a29(ext), .a29_o(a29o), .a29_oe(a29oe), .boot_pin(bpin), .irq_n(irq_n),
    .fault_n(fault_n), .a29_pin(a29p));

  // ----------------------------------------
  // Clock, pulse counters, checks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counted on the rising edge, so a stuck level shows as extra cycles
  always @(posedge clk) begin
    if (fault === 1'b1) nf++;
    if (irq === 1'b1) ni++;
  end

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_boot();
    logic [1:0] exp [3] = '{BOOT_W8, BOOT_W32, BOOT_W16};
    for (int m = 0; m < 3; m++) begin
      rstn = 1'b0;
      bmode = 2'(m);
      repeat (3) @(negedge clk);
      chk("valid in reset", 4'h0, 4'(bvalid));
      chk("strobes in reset", 4'hF, cas);
      rstn = 1'b1;
      @(negedge clk);
      chk("boot width", 4'(exp[m]), 4'(bw));
      chk("valid", 4'h1, 4'(bvalid));
    end
  endtask : t_boot

  task automatic t_dram();
    for (int n = 0; n < 4; n++) begin
      col = 1'b1;
      lanes = 4'h1 << n;
      @(negedge clk);
      chk("mux col", 4'h1, 4'(mux));
      chk("lane strobe", ~(4'h1 << n), cas);
    end
    col = 1'b0;
    lanes = 4'h0;
    @(negedge clk);
    chk("mux row", 4'h0, 4'(mux));
    chk("strobes idle", 4'hF, cas);
  endtask : t_dram

  task automatic t_sram();
    sram = 2'h3;
    acc = 1'b1;
    for (int b = 0; b < 2; b++) begin
      bank = 1'(b);
      @(negedge clk);
      chk("select 0", 4'(b), 4'(sel0));
      chk("select 1", 4'(1 - b), 4'(sel1));
    end
    // Bank 1 configured as DRAM: no select
    sram = 2'h1;
    @(negedge clk);
    chk("select 1 dram", 4'h1, 4'(sel1));
    acc = 1'b0;
  endtask : t_sram

  task automatic t_shared();
    hold = 1'b1;
    opp = 1'b1;
    ext = 1'b1;
    @(negedge clk);
    chk("regain req", 4'h0, 4'(shr));
    chk("a29 released", 4'h0, 4'(a29oe));
    @(negedge clk);
    chk("page bit", 4'h1, 4'(page));
    opp = 1'b0;
    @(negedge clk);
    chk("no req", 4'h1, 4'(shr));
    hold = 1'b0;
    ca29 = 1'b1;
    done = 1'b1;
    @(negedge clk);
    chk("a29 drive", 4'h1, 4'(a29oe));
    chk("a29 value", 4'h1, 4'(a29o));
    chk("strobe no grant", 4'h1, 4'(shr));
    grants = 4'hE;
    @(negedge clk);
    done = 1'b0;
    chk("strobe pulse", 4'h0, 4'(shr));
    @(negedge clk);
    chk("strobe end", 4'h1, 4'(shr));
    burst = 1'b1;
    repeat (5) begin
      @(negedge clk);
      chk("burst strobe", 4'h0, 4'(shr));
    end
    burst = 1'b0;
    @(negedge clk);
    chk("burst end", 4'h1, 4'(shr));
    grants = GRANTS_IDLE;
  endtask : t_shared

  task automatic t_fault();
    nf = 0;
    fault_on = 1'b1;
    repeat (5) @(negedge clk);
    chk("fault outside window", 4'h0, 4'(nf));
    dat = 1'b1;
    @(negedge clk);
    dat = 1'b0;
    lw = 1'b1;
    @(negedge clk);
    lw = 1'b0;
    fault_on = 1'b0;
    repeat (5) @(negedge clk);
    dat = 1'b1;
    @(negedge clk);
    dat = 1'b0;
    repeat (3) @(negedge clk);
    chk("fault pulses", 4'h2, 4'(nf));
  endtask : t_fault

  task automatic t_irq();
    ni = 0;
    irq_go = 1'b1;
    @(negedge clk);
    irq_go = 1'b0;
    repeat (6) @(negedge clk);
    chk("irq pulses", 4'h1, 4'(ni));
  endtask : t_irq

  initial begin
    {col, lanes, sram, acc, bank, dat, lw, hold, opp, done, burst, ca29, ext} = '0;
    {irq_go, fault_on} = '0;
    grants = GRANTS_IDLE;
    t_boot();
    t_dram();
    t_sram();
    t_shared();
    t_fault();
    t_irq();
    complete_run();
  end

  // Whole run is under a hundred cycles; allow far more
  initial begin
    #5000;
    n_errors++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
